// ==== design/dsh_host_port.sv ====
// Purpose: Host register port, four-wire serial or two-wire slave, chosen by strap
// Assumes: Host serial clocks are far slower than clock; rst is the power-down pin
// Notes: reg_rdata must be valid in the cycle reg_rd is high
`timescale 1ns/100ps
module dsh_host_port
	import dsh_pkg::*;
(
	input wire logic clock, // System clock, 100 MHz
	input wire logic rst, // Power-down reset, active high
	input wire logic iface_sel_strap, // Interface select strap pin
	input wire logic sck_scl, // Serial clock from host
	input wire logic si_sda_in, // Serial data in / two-wire data level
	output logic si_sda_out, // Two-wire data drive value, always low
	output logic si_sda_oe, // Two-wire data pulled low when high
	input wire logic chip_select_addr_sel_lo, // Chip select (low) or slave address bit 0
	input wire logic serial_out_addr_sel_hi_in, // Slave address bit 1 level
	output logic serial_out_addr_sel_hi_out, // Serial data out value
	output logic serial_out_addr_sel_hi_oe, // Serial data out driven when high
	output logic mode_i2c, // Selected protocol, 1 for two-wire
	output logic [7:0] reg_addr, // Register space address
	output logic [7:0] reg_wdata, // Register write data
	output logic reg_wr, // Register write strobe
	output logic reg_rd, // Register read strobe
	input wire logic [7:0] reg_rdata // Read data, valid while reg_rd
);
	import dsh_pkg::*;

	typedef struct packed {
		logic strap_done;
		logic [1:0] strap_cnt;
		logic mode;
		logic page;
		logic sck_p;
		logic sda_p;
		logic cs_p;
		logic lsb;
		logic [2:0] spi_cnt;
		logic spi_data;
		logic spi_rd;
		logic [6:0] spi_addr;
		logic so;
		logic so_oe;
		logic [7:0] sh;
		logic [7:0] tx;
		dsh_i2c_ph_t ph;
		logic [3:0] i_cnt;
		logic [6:0] i_ptr;
		logic i_lim;
		logic sda_oe;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
		logic rd_wait;
		logic rd_page;
		// Set between a read address ack and its clock rise, which is not a master ack
		logic rd_skip;
	} dsh_state_t;

	dsh_state_t s;
	dsh_state_t n;
	logic [DSH_SYNC_W-1:0] sync_q;
	logic sck_s, sda_s, cs_s, so_s, sel_s;
	logic sck_rise, sck_fall, cs_fall, i_start, i_stop, slv_match;
	logic wr_go, rd_go;
	logic [6:0] wr_a, rd_a;
	logic [7:0] wr_d, shn;

	dsh_sync #(.W(DSH_SYNC_W)) u_sync (
		.clock(clock),
		.rst(rst),
		.d({iface_sel_strap, serial_out_addr_sel_hi_in, chip_select_addr_sel_lo,
			si_sda_in, sck_scl}),
		.q(sync_q)
	);
	assign {sel_s, so_s, cs_s, sda_s, sck_s} = sync_q;
	assign sck_rise = sck_s & ~s.sck_p;
	assign sck_fall = ~sck_s & s.sck_p;
	assign cs_fall = ~cs_s & s.cs_p;
	// Data edges only count while the clock stays high, so our own drive is never seen
	assign i_start = s.sda_p & ~sda_s & sck_s & s.sck_p;
	assign i_stop = ~s.sda_p & sda_s & sck_s & s.sck_p;
	assign slv_match = (s.sh[7:1] == {DSH_SLV_FIXED, so_s, cs_s});

	always_comb begin
		n = s;
		n.wr = 1'b0;
		n.rd = 1'b0;
		n.sck_p = sck_s;
		n.sda_p = sda_s;
		n.cs_p = cs_s;
		wr_go = 1'b0;
		rd_go = 1'b0;
		wr_a = 7'h00;
		rd_a = 7'h00;
		wr_d = 8'h00;
		shn = 8'h00;
		if (s.rd_wait) begin
			n.tx = s.rd_page ? {7'h00, s.page} : reg_rdata;
			n.rd_wait = 1'b0;
		end
		if (!s.strap_done) begin
			// Strap is caught once the synchroniser holds a post-release level
			if (s.strap_cnt == DSH_STRAP_WAIT) begin
				n.strap_done = 1'b1;
				n.mode = sel_s;
			end else begin
				n.strap_cnt = s.strap_cnt + 2'h1;
			end
		end else if (s.mode == DSH_MODE_SPI) begin
			if (cs_s) begin
				n.spi_cnt = 3'h0;
				n.spi_data = 1'b0;
				n.spi_rd = 1'b0;
				n.so = 1'b0;
				n.so_oe = 1'b0;
			end else begin
				if (cs_fall) begin
					n.lsb = sck_s;
				end else if (sck_rise) begin
					shn = s.lsb ? {si_sda_in_bit(sda_s), s.sh[7:1]} : {s.sh[6:0], sda_s};
					n.spi_cnt = s.spi_cnt + 3'h1;
					if (!s.spi_data) begin
						if (s.spi_cnt == 3'h0) begin
							n.spi_rd = sda_s;
						end else begin
							n.sh = shn;
						end
						if (s.spi_cnt == 3'h7) begin
							n.spi_addr = s.lsb ? shn[7:1] : shn[6:0];
							n.spi_data = 1'b1;
							rd_go = s.spi_rd;
							rd_a = n.spi_addr;
						end
					end else begin
						n.sh = shn;
						if (s.spi_cnt == 3'h7) begin
							// Input is not looked at as write data during reads
							wr_go = ~s.spi_rd;
							wr_a = s.spi_addr;
							wr_d = shn;
							n.spi_addr = s.spi_addr + 7'h01;
							rd_go = s.spi_rd;
							rd_a = n.spi_addr;
						end
					end
				end else if (sck_fall && s.spi_data && s.spi_rd) begin
					n.so = s.lsb ? s.tx[s.spi_cnt] : s.tx[3'h7 - s.spi_cnt];
					n.so_oe = 1'b1;
				end
			end
		end else begin
			if (i_start) begin
				n.ph = DSH_I2C_ADDR;
				n.i_cnt = 4'h0;
				n.sda_oe = 1'b0;
				n.rd_skip = 1'b0;
			end else if (i_stop) begin
				n.ph = DSH_I2C_IDLE;
				n.i_cnt = 4'h0;
				n.sda_oe = 1'b0;
			end else if (s.ph != DSH_I2C_IDLE) begin
				if (sck_rise) begin
					if (s.i_cnt < DSH_ACK_SLOT) begin
						n.sh = {s.sh[6:0], sda_s};
						n.i_cnt = s.i_cnt + 4'h1;
					end else begin
						n.i_cnt = 4'h0;
						if (s.ph == DSH_I2C_RDATA) begin
							if (s.rd_skip) begin
								// Our own address ack; the first byte is already fetched
								n.rd_skip = 1'b0;
							end else if (sda_s) begin
								n.ph = DSH_I2C_IGN;
							end else if (s.i_lim || s.i_ptr == DSH_BURST_LIMIT) begin
								n.i_lim = 1'b1;
								n.tx = DSH_IGN_BYTE;
							end else begin
								n.i_ptr = s.i_ptr + 7'h01;
								rd_go = 1'b1;
								rd_a = n.i_ptr;
							end
						end
					end
				end else if (sck_fall) begin
					if (s.i_cnt == DSH_ACK_SLOT) begin
						n.sda_oe = 1'b1;
						unique case (s.ph)
							DSH_I2C_ADDR: begin
								if (!slv_match) begin
									n.sda_oe = 1'b0;
									n.ph = DSH_I2C_IGN;
								end else if (s.sh[0]) begin
									// Read starts at the pointer a prior write left
									n.ph = DSH_I2C_RDATA;
									n.rd_skip = 1'b1;
									rd_go = ~s.i_lim;
									rd_a = s.i_ptr;
									if (s.i_lim) begin
										n.tx = DSH_IGN_BYTE;
									end
								end else begin
									n.ph = DSH_I2C_REG;
								end
							end
							DSH_I2C_REG: begin
								n.i_ptr = s.sh[6:0];
								n.i_lim = 1'b0;
								n.ph = DSH_I2C_WDATA;
							end
							DSH_I2C_WDATA: begin
								// Excess burst bytes are still acked but dropped
								wr_go = ~s.i_lim;
								wr_a = s.i_ptr;
								wr_d = s.sh;
								if (s.i_ptr == DSH_BURST_LIMIT) begin
									n.i_lim = 1'b1;
								end else if (!s.i_lim) begin
									n.i_ptr = s.i_ptr + 7'h01;
								end
							end
							DSH_I2C_RDATA, DSH_I2C_IGN, DSH_I2C_IDLE: begin
								n.sda_oe = 1'b0;
							end
						endcase
					end else if (s.ph == DSH_I2C_RDATA) begin
						n.sda_oe = ~s.tx[3'h7 - s.i_cnt[2:0]];
					end else begin
						n.sda_oe = 1'b0;
					end
				end
			end
		end
		// Each byte goes out as its own access; ascending order gives MSB byte first
		if (wr_go) begin
			if (wr_a == DSH_PAGE_REG_ADDR) begin
				if (wr_d == DSH_PAGE_FLIP_VAL) begin
					n.page = ~s.page;
				end
			end else begin
				n.wr = 1'b1;
				n.addr = {s.page, wr_a};
				n.wdata = wr_d;
			end
		end
		if (rd_go) begin
			n.rd_wait = 1'b1;
			n.rd_page = (rd_a == DSH_PAGE_REG_ADDR);
			if (rd_a != DSH_PAGE_REG_ADDR) begin
				n.rd = 1'b1;
				n.addr = {s.page, rd_a};
			end
		end
	end

	function automatic logic si_sda_in_bit(input logic b);
		si_sda_in_bit = b;
	endfunction

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign si_sda_out = 1'b0;
	assign si_sda_oe = s.sda_oe;
	assign serial_out_addr_sel_hi_out = s.so;
	assign serial_out_addr_sel_hi_oe = s.so_oe;
	assign mode_i2c = s.mode;
	assign reg_addr = s.addr;
	assign reg_wdata = s.wdata;
	assign reg_wr = s.wr;
	assign reg_rd = s.rd;

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence spi_addr_end_s;
		s.strap_done && s.mode == DSH_MODE_SPI && !cs_s && sck_rise && !s.spi_data
			&& s.spi_cnt == 3'h7;
	endsequence
	sequence spi_data_end_s;
		s.strap_done && s.mode == DSH_MODE_SPI && !cs_s && sck_rise && s.spi_data
			&& s.spi_cnt == 3'h7;
	endsequence

	strap_catch_a: assert property (s.strap_done && !$past(s.strap_done) |-> s.mode == $past(sel_s))
		else $error("protocol not taken from strap");
	mode_hold_a: assert property (s.strap_done |=> $stable(s.mode) && s.strap_done)
		else $error("protocol changed after start-up");
	page_flip_a: assert property (wr_go && wr_a == DSH_PAGE_REG_ADDR && wr_d == DSH_PAGE_FLIP_VAL |=> s.page != $past(s.page) && !s.wr)
		else $error("page did not flip");
	page_addr_a: assert property (s.wr || s.rd |-> s.addr[7] == s.page && s.addr[6:0] != DSH_PAGE_REG_ADDR)
		else $error("access outside current page");
	spi_held_a: assert property (s.mode == DSH_MODE_SPI && cs_s ##1 cs_s |-> s.spi_cnt == 3'h0 && !s.spi_data && !s.so_oe)
		else $error("serial port not held while deselected");
	order_pick_a: assert property (s.strap_done && s.mode == DSH_MODE_SPI && cs_fall |=> s.lsb == $past(sck_s))
		else $error("bit order not taken at select");
	dir_bit_a: assert property (spi_addr_end_s |=> s.spi_data ##0 (s.rd == s.spi_rd || s.rd_page) ##[0:2] !s.wr)
		else $error("direction bit misread");
	half_dup_a: assert property (s.so_oe |-> s.spi_rd && s.spi_data && !s.wr)
		else $error("output driven during a write");
	burst_inc_a: assert property (spi_data_end_s |=> s.spi_addr == $past(s.spi_addr) + 7'h01)
		else $error("burst address did not increment");
	lim_stop_a: assert property (s.i_lim |-> s.i_ptr == DSH_BURST_LIMIT)
		else $error("two-wire pointer passed limit");
	slv_ack_a: assert property (s.mode == DSH_MODE_I2C && sck_fall && s.ph == DSH_I2C_ADDR && s.i_cnt == DSH_ACK_SLOT |=> s.sda_oe == $past(slv_match))
		else $error("slave address ack wrong");
endmodule

// ==== design/dsh_pkg.sv ====
// Purpose: Shared constants and types for the dual serial host register port
// Assumes: 7-bit host address, 8-bit data, one page bit
// Notes: Reset value of the whole port state is all zeros
package dsh_pkg;
	localparam logic [6:0] DSH_PAGE_REG_ADDR = 7'h7f;
	localparam logic [7:0] DSH_PAGE_FLIP_VAL = 8'h01;
	localparam logic [6:0] DSH_BURST_LIMIT = 7'h7f;
	// Fixed upper slave address bits, value is arbitrary
	localparam logic [4:0] DSH_SLV_FIXED = 5'h0b;
	localparam logic DSH_PAGE_RST = 1'b0;
	localparam logic DSH_MODE_SPI = 1'b0;
	localparam logic DSH_MODE_I2C = 1'b1;
	localparam logic [1:0] DSH_STRAP_WAIT = 2'h3;
	localparam logic [7:0] DSH_IGN_BYTE = 8'hff;
	localparam logic [3:0] DSH_ACK_SLOT = 4'h8;
	localparam int DSH_SYNC_W = 5;
	typedef enum logic [2:0] {
		DSH_I2C_IDLE,
		DSH_I2C_ADDR,
		DSH_I2C_REG,
		DSH_I2C_WDATA,
		DSH_I2C_RDATA,
		DSH_I2C_IGN
	} dsh_i2c_ph_t;
endpackage

// ==== design/dsh_sync.sv ====
// Purpose: Two-stage synchronisers for the pin inputs
// Assumes: Inputs are asynchronous to clock
// Notes: First stage is read only by the second stage
`timescale 1ns/100ps
module dsh_sync #(
	parameter int W = 1
) (
	input wire logic clock, // System clock
	input wire logic rst, // Asynchronous reset, active high
	input wire logic [W-1:0] d, // Raw pin levels
	output logic [W-1:0] q // Synchronised levels
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic meta_q;
			logic sync_q;
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					meta_q <= 1'b0;
					sync_q <= 1'b0;
				end else begin
					meta_q <= d[i];
					sync_q <= meta_q;
				end
			end
			assign q[i] = sync_q;
		end
	endgenerate
endmodule

// ==== dv/dsh_host_bfm.sv ====
// Purpose: Host master model for the four-wire and two-wire register port
// Assumes: 80 ns link period built from 20 ns steps on falling system clock edges
// Notes: sdo doubles as the open-drain release level in two-wire mode
`timescale 1ns/100ps
module dsh_host_bfm (
	input wire logic clock, // System clock
	input wire logic sdi, // Level seen from the device
	output logic sck = 1'b0, // Host serial clock
	output logic sdo = 1'b1, // Host data, 1 releases the two-wire line
	output logic cs_n = 1'b1 // Chip select, active low
);
	task automatic w(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic spi_byte(input logic [7:0] b, input logic lsb, output logic [7:0] r);
		for (int i = 0; i < 8; i++) begin
			sck <= 1'b0;
			sdo <= lsb ? b[i] : b[7-i];
			w(4);
			sck <= 1'b1;
			w(4);
			// Sampled just before the next fall, where the device data is settled
			r = lsb ? {sdi, r[7:1]} : {r[6:0], sdi};
		end
	endtask
	task automatic spi_begin(input logic lsb, input logic rd, input logic [6:0] a);
		logic [7:0] r;
		sck <= lsb;
		w(4);
		cs_n <= 1'b0;
		w(4);
		spi_byte(lsb ? {a, rd} : {rd, a}, lsb, r);
	endtask
	task automatic spi_end();
		w(8);
		cs_n <= 1'b1;
		w(8);
	endtask
	task automatic i2c_bit(input logic b, output logic s);
		sdo <= b;
		w(2);
		sck <= 1'b1;
		w(4);
		s = sdi;
		sck <= 1'b0;
		w(2);
	endtask
	task automatic i2c_byte(input logic [7:0] b, input logic m, output logic [7:0] r,
		output logic ack);
		for (int i = 7; i >= 0; i--)
			i2c_bit(b[i], r[i]);
		i2c_bit(m, ack);
		ack = ~ack;
	endtask
	task automatic i2c_start();
		sdo <= 1'b1;
		w(2);
		sck <= 1'b1;
		w(2);
		sdo <= 1'b0;
		w(2);
		sck <= 1'b0;
		w(2);
	endtask
	task automatic i2c_stop();
		sdo <= 1'b0;
		w(2);
		sck <= 1'b1;
		w(2);
		sdo <= 1'b1;
		w(4);
	endtask
endmodule

// ==== dv/tb.sv ====
// Purpose: Self-checking bench for the dual host register port
// Assumes: Register file is a random array answering reads in the same cycle
// Notes: Strap changes only across a reset, since the port picks it once
`timescale 1ns/100ps
module tb;
	import dsh_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic strap = 1'b0;
	logic [1:0] sel = 2'h0;
	logic sck, sdo, cs_n, sda_oe, so_out, so_oe, mode, wr, rd;
	logic [7:0] addr, wdata;
	logic [7:0] mem [256];
	logic [15:0] wq [$];
	int error_cnt = 0;
	int tests_run = 0;
	wire logic sda = sdo & ~sda_oe;
	wire logic so_pin = so_oe ? so_out : sel[1];
	wire logic cs_pin = strap ? sel[0] : cs_n;
	// Released serial out shows the inverse so a stale bit never passes
	wire logic hdi = strap ? sda : (so_oe ? so_out : ~so_out);
	always #5 clock = ~clock;
	always @(posedge clock) begin
		if (wr)
			wq.push_back({addr, wdata});
	end
	dsh_host_port dut_u (
		.clock(clock), .rst(rst), .iface_sel_strap(strap), .sck_scl(sck),
		.si_sda_in(sda), .si_sda_out(), .si_sda_oe(sda_oe),
		.chip_select_addr_sel_lo(cs_pin), .serial_out_addr_sel_hi_in(so_pin),
		.serial_out_addr_sel_hi_out(so_out), .serial_out_addr_sel_hi_oe(so_oe),
		.mode_i2c(mode), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
		.reg_rdata(mem[addr])
	);
	dsh_host_bfm h (.clock(clock), .sdi(hdi), .sck(sck), .sdo(sdo), .cs_n(cs_n));
	task automatic conclude();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wchk(input logic [15:0] e);
		int k;
		k = 0;
		while (wq.size() == 0 && k < 60) begin
			@(negedge clock);
			k++;
		end
		chk("write", e, wq.size() > 0 ? wq.pop_front() : 16'hxxxx);
		if (k == 60)
			conclude();
	endtask
	task automatic reset(input logic s);
		@(negedge clock);
		rst <= 1'b1;
		strap <= s;
		sel <= 2'($urandom);
		repeat (16) @(negedge clock);
		rst <= 1'b0;
		repeat (12) @(negedge clock);
		chk("mode", {15'h0, s}, {15'h0, mode});
	endtask
	task automatic ib(input logic [7:0] b, input logic e);
		logic [7:0] r;
		logic k;
		h.i2c_byte(b, 1'b1, r, k);
		chk("ack", {15'h0, e}, {15'h0, k});
	endtask
	initial begin
		logic [6:0] a, sa;
		logic [7:0] d, r;
		logic [7:0] ex [3];
		logic k, pg, lsb;
		void'($urandom(32'hf545a4de));
		foreach (mem[i])
			mem[i] = 8'($urandom);
		reset(DSH_MODE_SPI);
		pg = DSH_PAGE_RST;
		for (int t = 0; t < 6; t++) begin
			lsb = t[0];
			a = 7'($urandom_range(125));
			d = 8'($urandom);
			h.spi_begin(lsb, 1'b0, a);
			h.spi_byte(d, lsb, r);
			h.spi_byte(~d, lsb, r);
			h.spi_end();
			wchk({pg, a, d});
			wchk({pg, a + 7'h1, ~d});
			h.spi_begin(lsb, 1'b1, a);
			h.spi_byte(8'($urandom), lsb, r);
			chk("spi read", {8'h0, mem[{pg, a}]}, {8'h0, r});
			h.spi_byte(8'($urandom), lsb, r);
			chk("spi burst", {8'h0, mem[{pg, a + 7'h1}]}, {8'h0, r});
			h.spi_end();
			h.spi_begin(lsb, 1'b0, DSH_PAGE_REG_ADDR);
			h.spi_byte(DSH_PAGE_FLIP_VAL, lsb, r);
			h.spi_end();
			pg = ~pg;
		end
		reset(DSH_MODE_I2C);
		sa = {DSH_SLV_FIXED, sel};
		h.i2c_start();
		ib({sa, 1'b0}, 1'b1);
		ib({1'b0, a}, 1'b1);
		ib(d, 1'b1);
		h.i2c_stop();
		wchk({1'b0, a, d});
		h.i2c_start();
		ib({sa ^ 7'h01, 1'b0}, 1'b0);
		h.i2c_stop();
		h.i2c_start();
		ib({sa, 1'b0}, 1'b1);
		ib(8'h7d, 1'b1);
		ib(d, 1'b1);
		ib(~d, 1'b1);
		ib(8'h00, 1'b1);
		ib(8'h01, 1'b1);
		h.i2c_stop();
		wchk({8'h7d, d});
		wchk({8'h7e, ~d});
		chk("spare", 16'h0, 16'(wq.size()));
		ex = '{mem[8'h7e], 8'h00, DSH_IGN_BYTE};
		h.i2c_start();
		ib({sa, 1'b0}, 1'b1);
		ib(8'h7e, 1'b1);
		h.i2c_start();
		ib({sa, 1'b1}, 1'b1);
		for (int j = 0; j < 3; j++) begin
			h.i2c_byte(8'hff, j == 2, r, k);
			chk("i2c read", {8'h0, ex[j]}, {8'h0, r});
		end
		h.i2c_stop();
		conclude();
	end
endmodule
